// File: rtl/cfi_pkg.sv
// constants for the checker fault injection block
// assumes one checker clock domain and one test clock domain
package cfi_pkg;
    localparam int CFI_IR_W = 10;
    localparam logic [9:0] CFI_IR_INJECT = 10'h015;
    localparam int CFI_INJ_W = 21;
    localparam int CFI_TYPE_HI = 20;
    localparam int CFI_TYPE_LO = 19;
    localparam int CFI_LOC_HI = 18;
    localparam int CFI_LOC_LO = 8;
    localparam int CFI_VAL_HI = 7;
    localparam int CFI_VAL_LO = 0;
    localparam logic [20:0] CFI_INJ_RESET = 21'h000000;
    localparam int CFI_SIG_W = 16;
    localparam logic [15:0] CFI_SIG_CLEAN = 16'h0000;
    localparam int CFI_LOW_GAP_CYC = 32;
    localparam int CFI_GAP_CNT_W = 6;
    localparam int CFI_FRAME_BYTES = 2048;
    localparam int CFI_FRAME_ADDR_W = 11;
    localparam logic [1:0] CFI_TYPE_NONE = 2'h0;
    localparam logic [1:0] CFI_TYPE_SINGLE = 2'h1;
    localparam logic [1:0] CFI_TYPE_DOUBLE = 2'h2;
    typedef enum logic [1:0] {
        CFI_ST_IDLE = 2'h0,
        CFI_ST_FLAG = 2'h1,
        CFI_ST_GAP = 2'h3
    } cfi_flag_st_t;
endpackage

// File: rtl/cfi_tap_dr.sv
// injection data register on the test clock: instruction decode and shift
// assumes test access port state strobes arrive on the test clock
`timescale 1ns/1ps
module cfi_tap_dr
    import cfi_pkg::*;
(
    input wire logic tck,
    input wire logic reset_n,
    input wire logic [CFI_IR_W-1:0] ir_value,
    input wire logic user_mode_tck,
    input wire logic tdi,
    input wire logic capture_dr,
    input wire logic shift_dr,
    input wire logic update_dr,
    output logic tdo_r,
    output logic sel_r,
    output logic [CFI_INJ_W-1:0] dr_r,
    output logic upd_tgl_r
);
    logic [CFI_INJ_W-1:0] dr_nxt;
    logic tdo_nxt;
    logic sel_nxt;
    logic upd_tgl_nxt;

    always_comb begin
        sel_nxt = (ir_value == CFI_IR_INJECT) && user_mode_tck;
        dr_nxt = dr_r;
        tdo_nxt = tdo_r;
        upd_tgl_nxt = upd_tgl_r;
        if (sel_r && shift_dr) begin
            tdo_nxt = dr_r[0];
            dr_nxt = {tdi, dr_r[CFI_INJ_W-1:1]};
        end
        if (sel_r && update_dr) begin
            upd_tgl_nxt = ~upd_tgl_r;
        end
        if (capture_dr) begin
            tdo_nxt = tdo_r;
        end
    end

    always_ff @(posedge tck or negedge reset_n) begin
        if (!reset_n) begin
            dr_r <= CFI_INJ_RESET;
            tdo_r <= 1'b0;
            sel_r <= 1'b0;
            upd_tgl_r <= 1'b0;
        end else begin
            dr_r <= dr_nxt;
            tdo_r <= tdo_nxt;
            sel_r <= sel_nxt;
            upd_tgl_r <= upd_tgl_nxt;
        end
    end
endmodule

// File: rtl/cfi_top.sv
// fault injection and error flag logic beside the background checker
// assumes the checker drives frame strobes and signatures on clk,
// and the test access port controller runs on tck
`timescale 1ns/1ps
// Notes on behaviour
// - injection instruction accepted only in user mode
// - decode instruction, link 21-bit register to tdi/tdo
// - hold transfer during last and first frame
// - inject only in first frame; status always readable
// - type bits: 01 single, 10 double, 00 none
// - both type bits set means no injection
// - middle field gives byte location
// - low byte marks bits to flip
// - invert selected readback bits seen by checker
// - valid injection enters error test mode
// - error flag high on detected corruption
// - checking disabled: pin is user input/output
// - selectable open-drain mode on error flag
// - primitive error output has dedicated path
// - 16-bit signature, zero means clean frame
// - internal register takes test register on update
// - flag low 32 cycles before next assertion
module cfi_top
    import cfi_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic tck,
    input wire logic [CFI_IR_W-1:0] ir_value,
    input wire logic tdi,
    input wire logic capture_dr,
    input wire logic shift_dr,
    input wire logic update_dr,
    output logic tdo,
    output logic inject_sel,
    input wire logic user_mode,
    input wire logic check_enable,
    input wire logic open_drain_mode,
    input wire logic frame_start,
    input wire logic first_frame,
    input wire logic last_frame,
    input wire logic frame_done,
    input wire logic [CFI_SIG_W-1:0] frame_signature,
    input wire logic [CFI_FRAME_ADDR_W-1:0] rb_byte_addr,
    input wire logic [7:0] rb_byte_in,
    output logic [7:0] rb_byte_out,
    input wire logic core_err_sel,
    input wire logic core_err_in,
    input wire logic user_io_out,
    input wire logic user_io_oe,
    input wire logic err_pin_in,
    output logic err_pin_out,
    output logic err_pin_oe,
    output logic user_io_in,
    output logic error_test_mode,
    output logic [CFI_INJ_W-1:0] inject_setup
);
    logic um_t1_r;
    logic um_t2_r;
    logic upd_s1_r;
    logic upd_s2_r;
    logic upd_s3_r;
    logic [CFI_INJ_W-1:0] dr_val;
    logic upd_tgl;
    logic pin_s1_r;
    logic pin_s2_r;

    cfi_tap_dr u_tap (
        .tck(tck),
        .reset_n(reset_n),
        .ir_value(ir_value),
        .user_mode_tck(um_t2_r),
        .tdi(tdi),
        .capture_dr(capture_dr),
        .shift_dr(shift_dr),
        .update_dr(update_dr),
        .tdo_r(tdo),
        .sel_r(inject_sel),
        .dr_r(dr_val),
        .upd_tgl_r(upd_tgl)
    );

    // user mode level into test clock domain
    always_ff @(posedge tck or negedge reset_n) begin
        if (!reset_n) begin
            um_t1_r <= 1'b0;
            um_t2_r <= 1'b0;
        end else begin
            um_t1_r <= user_mode;
            um_t2_r <= um_t1_r;
        end
    end

    // update toggle and pin level into checker clock domain
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            upd_s1_r <= 1'b0;
            upd_s2_r <= 1'b0;
            upd_s3_r <= 1'b0;
            pin_s1_r <= 1'b0;
            pin_s2_r <= 1'b0;
        end else begin
            upd_s1_r <= upd_tgl;
            upd_s2_r <= upd_s1_r;
            upd_s3_r <= upd_s2_r;
            pin_s1_r <= err_pin_in;
            pin_s2_r <= pin_s1_r;
        end
    end

    function automatic logic [1:0] cfi_type(input logic [CFI_INJ_W-1:0] w);
        logic [1:0] t;
        t = w[CFI_TYPE_HI:CFI_TYPE_LO];
        if (t == CFI_TYPE_SINGLE || t == CFI_TYPE_DOUBLE) begin
            cfi_type = t;
        end else begin
            cfi_type = CFI_TYPE_NONE;
        end
    endfunction

    // injection register and its transfer window
    logic [CFI_INJ_W-1:0] inj_r;
    logic [CFI_INJ_W-1:0] inj_nxt;
    logic pend_r;
    logic pend_nxt;
    logic hold_r;
    logic hold_nxt;
    logic test_r;
    logic test_nxt;
    logic upd_evt;

    assign upd_evt = upd_s2_r ^ upd_s3_r;

    always_comb begin
        inj_nxt = inj_r;
        pend_nxt = pend_r | upd_evt;
        hold_nxt = hold_r;
        test_nxt = test_r;
        if (frame_start && last_frame) begin
            hold_nxt = 1'b1;
        end else if (frame_done && first_frame) begin
            hold_nxt = 1'b0;
        end
        if (pend_r && !hold_r && !(frame_start && last_frame) && user_mode) begin
            inj_nxt = dr_val;
            pend_nxt = upd_evt;
            if (cfi_type(dr_val) != CFI_TYPE_NONE) begin
                test_nxt = 1'b1;
            end else begin
                test_nxt = 1'b0;
            end
        end
        if (!user_mode) begin
            test_nxt = 1'b0;
            pend_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            inj_r <= CFI_INJ_RESET;
            pend_r <= 1'b0;
            hold_r <= 1'b0;
            test_r <= 1'b0;
        end else begin
            inj_r <= inj_nxt;
            pend_r <= pend_nxt;
            hold_r <= hold_nxt;
            test_r <= test_nxt;
        end
    end

    // readback corruption in the first frame only
    logic [7:0] rb_nxt;
    logic [7:0] rb_r;
    logic [CFI_FRAME_ADDR_W-1:0] loc;
    logic [1:0] ty;

    always_comb begin
        ty = cfi_type(inj_r);
        loc = inj_r[CFI_LOC_HI:CFI_LOC_LO];
        rb_nxt = rb_byte_in;
        if (first_frame && test_r) begin
            if (ty != CFI_TYPE_NONE && rb_byte_addr == loc) begin
                rb_nxt = rb_byte_in ^ inj_r[CFI_VAL_HI:CFI_VAL_LO];
            end else if (ty == CFI_TYPE_DOUBLE &&
                         rb_byte_addr == CFI_FRAME_ADDR_W'(loc + 1'b1)) begin
                rb_nxt = rb_byte_in ^ inj_r[CFI_VAL_HI:CFI_VAL_LO];
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rb_r <= 8'h00;
        end else begin
            rb_r <= rb_nxt;
        end
    end

    // error flag sequencing with low gap
    cfi_flag_st_t st_r;
    cfi_flag_st_t st_nxt;
    logic [CFI_GAP_CNT_W-1:0] gap_r;
    logic [CFI_GAP_CNT_W-1:0] gap_nxt;
    logic err_seen;

    always_comb begin
        err_seen = frame_done && (frame_signature != CFI_SIG_CLEAN);
        st_nxt = st_r;
        gap_nxt = gap_r;
        case (st_r)
            CFI_ST_IDLE: begin
                if (err_seen && check_enable) begin
                    st_nxt = CFI_ST_FLAG;
                end
            end
            CFI_ST_FLAG: begin
                if (frame_done) begin
                    st_nxt = CFI_ST_GAP;
                    gap_nxt = CFI_GAP_CNT_W'(CFI_LOW_GAP_CYC - 1);
                end
            end
            CFI_ST_GAP: begin
                if (gap_r == '0) begin
                    st_nxt = CFI_ST_IDLE;
                end else begin
                    gap_nxt = gap_r - 1'b1;
                end
            end
            default: st_nxt = CFI_ST_IDLE;
        endcase
        if (!check_enable) begin
            st_nxt = CFI_ST_IDLE;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= CFI_ST_IDLE;
            gap_r <= '0;
        end else begin
            st_r <= st_nxt;
            gap_r <= gap_nxt;
        end
    end

    // pin drive
    logic flag;
    logic po_nxt;
    logic poe_nxt;
    logic po_r;
    logic poe_r;
    logic uin_r;

    always_comb begin
        flag = core_err_sel ? core_err_in : (st_r == CFI_ST_FLAG);
        if (!check_enable) begin
            po_nxt = user_io_out;
            poe_nxt = user_io_oe;
        end else if (open_drain_mode) begin
            po_nxt = 1'b0;
            poe_nxt = ~flag;
        end else begin
            po_nxt = flag;
            poe_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            po_r <= 1'b0;
            poe_r <= 1'b0;
            uin_r <= 1'b0;
        end else begin
            po_r <= po_nxt;
            poe_r <= poe_nxt;
            uin_r <= pin_s2_r;
        end
    end

    assign err_pin_out = po_r;
    assign err_pin_oe = poe_r;
    assign user_io_in = uin_r;
    assign rb_byte_out = rb_r;
    assign error_test_mode = test_r;
    assign inject_setup = inj_r;
endmodule

// File: testbench/cfi_top_assertions.sv
// checker on the fault injection block ports
// assumes a bind to cfi_top with clk and tck domains
`timescale 1ns/1ps
module cfi_chk
    import cfi_pkg::*;
(
    input wire logic clk,
    input wire logic tck,
    input wire logic reset_n,
    input wire logic [CFI_IR_W-1:0] ir_value,
    input wire logic user_mode,
    input wire logic check_enable,
    input wire logic open_drain_mode,
    input wire logic frame_done,
    input wire logic first_frame,
    input wire logic [CFI_SIG_W-1:0] frame_signature,
    input wire logic [7:0] rb_byte_in,
    input wire logic [7:0] rb_byte_out,
    input wire logic user_io_out,
    input wire logic user_io_oe,
    input wire logic err_pin_out,
    input wire logic err_pin_oe,
    input wire logic inject_sel,
    input wire logic [CFI_INJ_W-1:0] inject_setup
);
    logic [5:0] low_r;
    logic [5:0] low_nxt;
    always_comb begin
        low_nxt = low_r;
        if (err_pin_out) begin
            low_nxt = 6'h00;
        end else if (low_r != 6'h3F) begin
            low_nxt = low_r + 6'h01;
        end
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            low_r <= 6'h3F;
        end else begin
            low_r <= low_nxt;
        end
    end
    sequence err_s;
        frame_done && frame_signature != CFI_SIG_CLEAN;
    endsequence
    sequence idle_s;
        check_enable && !open_drain_mode && low_r > 6'h28;
    endsequence
    sel_ir_a: assert property (@(posedge tck) disable iff (!reset_n)
        inject_sel |-> $past(ir_value) == CFI_IR_INJECT) else $error("select without code");
    sel_mode_a: assert property (@(posedge tck) disable iff (!reset_n)
        !user_mode [*4] |-> !inject_sel) else $error("select outside user mode");
    flag_rise_a: assert property (@(posedge clk) disable iff (!reset_n)
        idle_s ##0 err_s |-> ##2 err_pin_out) else $error("flag not raised");
    flag_gap_a: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(err_pin_out) && check_enable && $past(check_enable) |-> low_r >= 6'h20)
        else $error("flag low gap short");
    open_drain_a: assert property (@(posedge clk) disable iff (!reset_n)
        check_enable && open_drain_mode && $past(check_enable && open_drain_mode)
        |-> !err_pin_out) else $error("open drain drove high");
    user_io_a: assert property (@(posedge clk) disable iff (!reset_n)
        !check_enable && $past(!check_enable) |-> err_pin_out == $past(user_io_out)
        && err_pin_oe == $past(user_io_oe)) else $error("pin not user io");
    first_only_a: assert property (@(posedge clk) disable iff (!reset_n)
        $past(reset_n) && !$past(first_frame) |-> rb_byte_out == $past(rb_byte_in))
        else $error("corrupt outside first frame");
    bad_type_a: assert property (@(posedge clk) disable iff (!reset_n)
        $past(reset_n) && $past(inject_setup[20] == inject_setup[19])
        |-> rb_byte_out == $past(rb_byte_in)) else $error("corrupt with no type");
endmodule
bind cfi_top cfi_chk u_chk (.clk(clk), .tck(tck), .reset_n(reset_n), .ir_value(ir_value),
    .user_mode(user_mode), .check_enable(check_enable), .open_drain_mode(open_drain_mode),
    .frame_done(frame_done), .first_frame(first_frame), .frame_signature(frame_signature),
    .rb_byte_in(rb_byte_in), .rb_byte_out(rb_byte_out), .user_io_out(user_io_out),
    .user_io_oe(user_io_oe), .err_pin_out(err_pin_out), .err_pin_oe(err_pin_oe),
    .inject_sel(inject_sel), .inject_setup(inject_setup));

// File: testbench/cfi_jtag_host.sv
// test host model shifting the injection word
// assumes a free test clock and a 20 MHz checker clock setting
`timescale 1ns/1ps
module cfi_jtag_host
    import cfi_pkg::*;
(
    input wire logic tck,
    input wire logic tdo,
    output logic [CFI_IR_W-1:0] ir_value,
    output logic tdi,
    output logic capture_dr,
    output logic shift_dr,
    output logic update_dr
);
    initial begin
        ir_value = CFI_IR_INJECT;
        tdi = 1'b0;
        capture_dr = 1'b0;
        shift_dr = 1'b0;
        update_dr = 1'b0;
    end
    task automatic load(input logic [20:0] w, output logic [20:0] got);
        @(posedge tck) #2 shift_dr = 1'b1;
        for (int i = 0; i < CFI_INJ_W; i++) begin
            tdi = w[i];
            @(posedge tck) #2 got[i] = tdo;
        end
        shift_dr = 1'b0;
        tdi = ~tdi;
        update_dr = 1'b1;
        @(posedge tck) #2 update_dr = 1'b0;
    endtask
endmodule

// File: testbench/cfi_top_tb.sv
// bench for the fault injection block
// assumes cfi_top, cfi_jtag_host and the bound checker
`timescale 1ns/1ps
module cfi_top_tb;
    import cfi_pkg::*;
    logic clk = 1'b0, tck = 1'b0, reset_n = 1'b0, user_mode = 1'b1, check_enable = 1'b0;
    logic open_drain_mode = 1'b0, frame_start = 1'b0, first_frame = 1'b0;
    logic last_frame = 1'b0, frame_done = 1'b0, user_io_out = 1'b0, user_io_oe = 1'b0;
    logic core_err_sel = 1'b0, core_err_in = 1'b0;
    logic [15:0] frame_signature = 16'h0000;
    logic [10:0] rb_byte_addr = 11'h000;
    logic [7:0] rb_byte_in = 8'h00;
    logic [7:0] rb_byte_out;
    logic [9:0] ir_value;
    logic [20:0] inject_setup;
    logic tdi, capture_dr, shift_dr, update_dr, tdo, inject_sel;
    logic err_pin_out, err_pin_oe, user_io_in, error_test_mode;
    int n_errors = 0;
    int n_compared = 0;
    wire pin = err_pin_oe ? err_pin_out : 1'b1;
    always #25 clk = ~clk;
    initial begin
        #13;
        forever #40 tck = ~tck;
    end
    cfi_jtag_host u_host (.tck(tck), .tdo(tdo), .ir_value(ir_value), .tdi(tdi),
        .capture_dr(capture_dr), .shift_dr(shift_dr), .update_dr(update_dr));
    cfi_top u_dut (.clk(clk), .reset_n(reset_n), .tck(tck), .ir_value(ir_value), .tdi(tdi),
        .capture_dr(capture_dr), .shift_dr(shift_dr), .update_dr(update_dr), .tdo(tdo),
        .inject_sel(inject_sel), .user_mode(user_mode), .check_enable(check_enable),
        .open_drain_mode(open_drain_mode), .frame_start(frame_start),
        .first_frame(first_frame), .last_frame(last_frame), .frame_done(frame_done),
        .frame_signature(frame_signature), .rb_byte_addr(rb_byte_addr),
        .rb_byte_in(rb_byte_in), .rb_byte_out(rb_byte_out), .core_err_sel(core_err_sel),
        .core_err_in(core_err_in), .user_io_out(user_io_out), .user_io_oe(user_io_oe),
        .err_pin_in(pin), .err_pin_out(err_pin_out), .err_pin_oe(err_pin_oe),
        .user_io_in(user_io_in), .error_test_mode(error_test_mode),
        .inject_setup(inject_setup));
    task automatic test_done;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [20:0] got, input logic [20:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic wset(input logic [20:0] e);
        int i;
        for (i = 0; i < 20 && inject_setup !== e; i++) tick(1);
        chk(inject_setup, e);
        if (i == 20) test_done();
    endtask
    task automatic rb(input logic [10:0] a, input logic [7:0] d, input logic [7:0] e);
        rb_byte_addr = a;
        rb_byte_in = d;
        tick(1);
        chk(rb_byte_out, e);
    endtask
    task automatic pulse(input logic [15:0] s);
        frame_signature = s;
        frame_done = 1'b1;
        tick(1);
        frame_done = 1'b0;
    endtask
    task automatic t_inject;
        logic [20:0] got;
        chk(inject_sel, 1'b1);
        u_host.load(21'h18053C, got);
        wset(21'h18053C);
        first_frame = 1'b1;
        rb(11'h005, 8'hA5, 8'hA5);
        chk(error_test_mode, 1'b0);
        u_host.load(21'h08053C, got);
        chk(got, 21'h18053C);
        wset(21'h08053C);
        rb(11'h005, 8'hA5, 8'h99);
        rb(11'h006, 8'hA5, 8'hA5);
        chk(error_test_mode, 1'b1);
        u_host.load(21'h10053C, got);
        wset(21'h10053C);
        rb(11'h006, 8'h5A, 8'h66);
        first_frame = 1'b0;
        rb(11'h005, 8'hA5, 8'hA5);
    endtask
    task automatic t_hold;
        logic [20:0] got;
        last_frame = 1'b1;
        frame_start = 1'b1;
        tick(1);
        frame_start = 1'b0;
        last_frame = 1'b0;
        u_host.load(21'h0007FF, got);
        tick(6);
        chk(inject_setup, 21'h10053C);
        first_frame = 1'b1;
        pulse(16'h0000);
        first_frame = 1'b0;
        wset(21'h0007FF);
    endtask
    task automatic t_flag;
        check_enable = 1'b1;
        tick(40);
        pulse(16'h0001);
        tick(2);
        chk({err_pin_out, err_pin_oe}, 2'h3);
        pulse(16'h0000);
        pulse(16'h8000);
        tick(29);
        chk(err_pin_out, 1'b0);
        tick(12);
        pulse(16'h0000);
        tick(40);
        core_err_sel = 1'b1;
        core_err_in = 1'b1;
        tick(2);
        chk(err_pin_out, 1'b1);
        core_err_sel = 1'b0;
        tick(2);
        chk(err_pin_out, 1'b0);
        open_drain_mode = 1'b1;
        tick(2);
        pulse(16'h0001);
        tick(2);
        chk({err_pin_out, err_pin_oe, pin}, 3'h1);
        pulse(16'h0000);
        tick(2);
        chk(pin, 1'b0);
        check_enable = 1'b0;
        user_io_oe = 1'b1;
        user_io_out = 1'b1;
        tick(2);
        chk({err_pin_out, err_pin_oe}, 2'h3);
        user_io_out = 1'b0;
        tick(5);
        chk(user_io_in, 1'b0);
        user_io_oe = 1'b0;
        tick(5);
        chk(user_io_in, 1'b1);
    endtask
    initial begin
        repeat (12) @(posedge clk);
        #2 reset_n = 1'b1;
        tick(10);
        t_inject();
        t_hold();
        t_flag();
        user_mode = 1'b0;
        tick(12);
        chk({inject_sel, error_test_mode}, 2'h0);
        test_done();
    end
endmodule
